// >>> rtl/fpec_top.sv
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module fpec_top
    import fpec_pkg::*;
#(
    parameter int ERASE_CYCLES = fpec_pkg::ERASE_CYC
)(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [15:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // debug port programming
    input  wire fpec_pkg::fpec_dbg_req_t dbg_req,
    output logic                       dbg_ack,
    // data memory side and system
    output fpec_pkg::fpec_xram_t       xram,
    output logic                       core_stall,
    output logic                       sys_rst_req
);
    import fpec_pkg::*;

    localparam int CNT_W = $clog2(ERASE_CYCLES + 1);

    // elaboration checks
    if (ERASE_CYCLES < PAGE_BYTES)
        $error("erase count too short for page sweep");
    if (ERASE_CYCLES < WRITE_CYC)
        $error("erase count below write count");
    if (ERASE_CYC < ERASE_CYC_MIN || ERASE_CYC > ERASE_CYC_MAX)
        $error("erase count out of bounds");
    if (WRITE_CYC < WRITE_CYC_MIN || WRITE_CYC > WRITE_CYC_MAX)
        $error("write count out of bounds");

    // lock state to read code
    function automatic logic [1:0] key_code(input fpec_key_t k);
        unique case (k)
            KS_LOCKED:  key_code = 2'h0;
            KS_FIRST:   key_code = 2'h1;
            KS_OPEN:    key_code = 2'h2;
            KS_BLOCKED: key_code = 2'h3;
        endcase
    endfunction : key_code

    // state
    logic [7:0]        mem [0:(1<<ADDR_W)-1];
    logic [1:0]        ctrl_q;
    fpec_key_t         key_q;
    fpec_key_t         key_d;
    logic              busy_q;
    logic              erase_q;
    logic              dbg_op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0]        data_q;
    logic [CNT_W-1:0]  cnt_q;
    logic              ferr_q;
    logic              init_q;
    logic [31:0]       prdata_q;
    logic              pready_q;
    logic              pslverr_q;
    logic              dbg_ack_q;
    fpec_xram_t        xram_q;
    logic              rst_req_q;

    // apb decode
    wire               access   = psel & penable;
    wire               commit   = access & pready_q;
    wire               is_win   = paddr[WIN_BIT];
    wire [ADDR_W-1:0]  win_addr = paddr[14:2];
    wire               hit_ctrl = (paddr == OFS_CTRL);
    wire               hit_key  = (paddr == OFS_KEY);
    wire               hit_stat = (paddr == OFS_STAT);
    wire               hit_win  = is_win & (paddr[1:0] == 2'h0);
    wire               mapped   = hit_ctrl | hit_key | hit_stat | hit_win;
    // stalled while busy or while debug owns the array
    wire               grant    = access & ~pready_q & ~busy_q & ~dbg_req.valid;
    wire               wr       = commit & pwrite & mapped;

    // write strobes
    wire               ctrl_wr  = wr & hit_ctrl;
    wire               key_wr   = wr & hit_key;
    wire               stat_wr  = wr & hit_stat;
    wire               move_wr  = wr & hit_win;
    wire [7:0]         wbyte    = pwdata[7:0];

    // routing of moves
    wire               routed   = move_wr & ctrl_q[CTRL_WEN_BIT];
    wire               to_xram  = move_wr & ~ctrl_q[CTRL_WEN_BIT];
    wire               illegal  = routed & (win_addr > USER_LIMIT);
    wire               legal    = routed & ~illegal;
    // software may start only when open and already initialised
    wire               sw_go    = legal & (key_q == KS_OPEN) & init_q;
    wire               early    = legal & (key_q != KS_OPEN);
    wire               dbg_go   = dbg_req.valid & ~busy_q & ~pready_q & ~dbg_ack_q;
    wire               start    = sw_go | dbg_go;

    // operation select
    wire               st_erase = sw_go ? ctrl_q[CTRL_EEN_BIT] : dbg_req.erase;
    wire [ADDR_W-1:0]  st_addr  = sw_go ? win_addr : dbg_req.addr;
    wire [7:0]         st_data  = sw_go ? wbyte : dbg_req.data;
    wire [CNT_W-1:0]   st_cnt   = st_erase ? CNT_W'(ERASE_CYCLES) : CNT_W'(WRITE_CYC);

    // timing and array writes
    wire               done     = busy_q & (cnt_q == CNT_W'(1));
    wire [CNT_W-1:0]   elapsed  = CNT_W'(ERASE_CYCLES) - cnt_q;
    wire               sweeping = erase_q & (elapsed < CNT_W'(PAGE_BYTES));
    wire               mem_we   = busy_q & (erase_q ? sweeping : done);
    wire [ADDR_W-1:0]  mem_addr = erase_q ? {addr_q[ADDR_W-1:PAGE_W], elapsed[PAGE_W-1:0]}
                                          : addr_q;
    wire [7:0]         mem_old  = mem[addr_q];
    wire [7:0]         mem_wd   = erase_q ? ERASED : (mem_old & data_q);

    // read mux, array reads ignore keys and enables
    wire [31:0]        rd_ctrl  = {30'h0, ctrl_q};
    wire [31:0]        rd_key   = {30'h0, key_code(key_q)};
    wire [31:0]        rd_stat  = {29'h0, init_q, ferr_q, busy_q};
    wire [31:0]        rd_win   = {24'h0, mem[win_addr]};
    wire [31:0]        rd_data  = hit_ctrl ? rd_ctrl :
                                  hit_key  ? rd_key  :
                                  hit_stat ? rd_stat :
                                  hit_win  ? rd_win  : 32'h0;

    // key state machine
    always_comb
    begin
        key_d = key_q;
        if (illegal)
            key_d = KS_LOCKED;
        else if (done & ~dbg_op_q)
            key_d = KS_LOCKED;
        else if (early)
            key_d = KS_BLOCKED;
        else if (key_wr)
        begin
            // only order and value matter, no timeout
            unique case (key_q)
                KS_LOCKED:  key_d = (wbyte == KEY_FIRST) ? KS_FIRST : KS_BLOCKED;
                KS_FIRST:   key_d = (wbyte == KEY_SECOND) ? KS_OPEN : KS_BLOCKED;
                KS_OPEN:    key_d = KS_BLOCKED;
                KS_BLOCKED: key_d = KS_BLOCKED;
            endcase
        end
    end

    // key register, locked on every reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            key_q <= KS_LOCKED;
        else
            key_q <= key_d;
    end

    // store control, write enable cleared by software or by an illegal write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= CTRL_RST;
        else if (illegal)
            ctrl_q <= CTRL_RST;
        else if (ctrl_wr)
            ctrl_q <= pwdata[1:0];
    end

    // operation sequencer, load on start and count down
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q   <= 1'b0;
            erase_q  <= 1'b0;
            dbg_op_q <= 1'b0;
            addr_q   <= '0;
            data_q   <= 8'h00;
            cnt_q    <= '0;
        end
        else if (start)
        begin
            busy_q   <= 1'b1;
            erase_q  <= st_erase;
            dbg_op_q <= dbg_go;
            addr_q   <= st_addr;
            data_q   <= st_data;
            cnt_q    <= st_cnt;
        end
        else if (busy_q)
        begin
            busy_q   <= ~done;
            cnt_q    <= cnt_q - CNT_W'(1);
        end
    end

    // array, no reset: contents are non-volatile
    always_ff @(posedge pclk)
    begin
        if (mem_we)
            mem[mem_addr] <= mem_wd;
    end

    // error flag, a fresh error beats the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ferr_q <= 1'b0;
        else if (illegal)
            ferr_q <= 1'b1;
        else if (stat_wr & pwdata[STAT_FERR])
            ferr_q <= 1'b0;
    end

    // initialised once the debug port finished an operation
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            init_q <= 1'b0;
        else if (done & dbg_op_q)
            init_q <= 1'b1;
    end

    // apb answer, one wait state minimum
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end
        else
        begin
            pready_q  <= grant;
            pslverr_q <= grant & ~mapped;
            prdata_q  <= (grant & ~pwrite) ? rd_data : 32'h0;
        end
    end

    // side outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dbg_ack_q <= 1'b0;
            xram_q    <= '0;
            rst_req_q <= 1'b0;
        end
        else
        begin
            dbg_ack_q <= dbg_go;
            xram_q.we <= to_xram;
            xram_q.addr <= to_xram ? win_addr : xram_q.addr;
            xram_q.data <= to_xram ? wbyte : xram_q.data;
            rst_req_q <= illegal;
        end
    end

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign dbg_ack     = dbg_ack_q;
    assign xram        = xram_q;
    assign core_stall  = busy_q;
    assign sys_rst_req = rst_req_q;

    // checking helpers
    logic [CNT_W-1:0] busy_len_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_len_q <= '0;
        else
            busy_len_q <= busy_q ? busy_len_q + CNT_W'(1) : '0;
    end

    wire [CNT_W-1:0] want_len = erase_q ? CNT_W'(ERASE_CYCLES - 1) : CNT_W'(WRITE_CYC - 1);

    sequence s_first_key;
        key_wr && key_q == KS_LOCKED && wbyte == KEY_FIRST && !early && !illegal;
    endsequence

    sequence s_bad_key;
        key_wr && key_q != KS_BLOCKED && !early && !illegal &&
        !(key_q == KS_LOCKED && wbyte == KEY_FIRST) &&
        !(key_q == KS_FIRST && wbyte == KEY_SECOND);
    endsequence

    a_key_first: assert property (@(posedge pclk) disable iff (!presetn)
        s_first_key |=> key_q == KS_FIRST)
        else $error("first key not taken");

    a_key_wrong: assert property (@(posedge pclk) disable iff (!presetn)
        s_bad_key |=> key_q == KS_BLOCKED)
        else $error("wrong key did not block");

    a_block_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        key_q == KS_BLOCKED && !illegal |=> key_q == KS_BLOCKED)
        else $error("block left without reset");

    a_early_block: assert property (@(posedge pclk) disable iff (!presetn)
        early |=> key_q == KS_BLOCKED && !busy_q)
        else $error("early attempt not blocked");

    a_op_length: assert property (@(posedge pclk) disable iff (!presetn)
        done |-> busy_len_q == want_len)
        else $error("operation length wrong");

    a_stall_apb: assert property (@(posedge pclk) disable iff (!presetn)
        busy_q && !done |=> !pready_q && core_stall)
        else $error("bus answered during operation");

    // last busy cycle still refuses the bus, the answer comes one edge later
    a_stall_end: assert property (@(posedge pclk) disable iff (!presetn)
        done |=> !pready_q && !core_stall)
        else $error("stall did not end after operation");

    a_debug_start: assert property (@(posedge pclk) disable iff (!presetn)
        dbg_go |=> dbg_ack && busy_q && dbg_op_q)
        else $error("debug request not started");

    a_relock_done: assert property (@(posedge pclk) disable iff (!presetn)
        done && !dbg_op_q |=> key_q == KS_LOCKED && !busy_q)
        else $error("lock not restored");

    a_wen_holds: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[CTRL_WEN_BIT] && !ctrl_wr && !illegal |=> ctrl_q[CTRL_WEN_BIT])
        else $error("write enable dropped");

    a_unrouted_move: assert property (@(posedge pclk) disable iff (!presetn)
        to_xram |=> xram.we && !busy_q && $stable(key_q))
        else $error("unrouted move disturbed flash");

    a_error_reset: assert property (@(posedge pclk) disable iff (!presetn)
        illegal |=> sys_rst_req && ferr_q && !busy_q ##1 !sys_rst_req)
        else $error("error reset not raised");

    // checks the stored byte, not the write expression, so a bad merge is caught
    a_prog_clears: assert property (@(posedge pclk) disable iff (!presetn)
        mem_we && !erase_q |=> (mem[addr_q] & ~$past(mem_old)) == 8'h00)
        else $error("program set a bit");

    a_blank_refuse: assert property (@(posedge pclk) disable iff (!presetn)
        legal && !init_q |=> !busy_q)
        else $error("blank device took software write");
endmodule : fpec_top

// >>> rtl/fpec_pkg.sv
package fpec_pkg;
    // address map, byte addresses on apb
    localparam logic [15:0] OFS_CTRL   = 16'h0000;
    localparam logic [15:0] OFS_KEY    = 16'h0004;
    localparam logic [15:0] OFS_STAT   = 16'h0008;
    localparam int          WIN_BIT    = 15;
    // field positions
    localparam int CTRL_WEN_BIT = 0;
    localparam int CTRL_EEN_BIT = 1;
    localparam int STAT_BUSY    = 0;
    localparam int STAT_FERR    = 1;
    localparam int STAT_INIT    = 2;
    // reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    // array geometry and key codes
    localparam int          ADDR_W     = 13;
    localparam int          PAGE_W     = 9;
    localparam int          PAGE_BYTES = 512;
    localparam logic [7:0]  KEY_FIRST  = 8'hA5;
    localparam logic [7:0]  KEY_SECOND = 8'hF1;
    localparam logic [7:0]  ERASED     = 8'hFF;
    localparam logic [12:0] USER_LIMIT = 13'h1DFF;
    // timing, clock 20 MHz
    localparam int CLK_NS       = 50;
    localparam int ERASE_TYP_US = 15000;
    localparam int ERASE_MIN_US = 10000;
    localparam int ERASE_MAX_US = 20000;
    localparam int WRITE_TYP_NS = 55000;
    localparam int WRITE_MIN_NS = 40000;
    localparam int WRITE_MAX_NS = 70000;
    localparam int ERASE_CYC     = ERASE_TYP_US * 1000 / CLK_NS;
    localparam int ERASE_CYC_MIN = (ERASE_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int ERASE_CYC_MAX = ERASE_MAX_US * 1000 / CLK_NS;
    localparam int WRITE_CYC     = WRITE_TYP_NS / CLK_NS;
    localparam int WRITE_CYC_MIN = (WRITE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int WRITE_CYC_MAX = WRITE_MAX_NS / CLK_NS;
    // lock states
    typedef enum logic [1:0] {KS_LOCKED, KS_FIRST, KS_OPEN, KS_BLOCKED} fpec_key_t;
    // debug port request, held until acknowledged
    typedef struct packed {
        logic              valid;
        logic              erase;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } fpec_dbg_req_t;
    // write toward data memory
    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } fpec_xram_t;
endpackage : fpec_pkg

// >>> dv/fpec_core_model.sv
`timescale 1ns/1ps
module fpec_core_model
(
    // clock
    input  wire logic        pclk,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [15:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // raised when a slave answer never came
    output logic             hung
);
    import fpec_pkg::*;

    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 16'h0000;
        pwdata  = 32'h0000_0000;
        hung    = 1'b0;
    end

    // one apb transfer, entered just after a rising edge; one idle edge at the end
    // so the next call never assigns psel twice in the same time step
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        int n;
        begin
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= wr;
            paddr   <= a;
            pwdata  <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do
            begin
                @(posedge pclk);
                n++;
            end
            while (pready !== 1'b1 && n < 5000);
            rd = prdata;
            err = pslverr;
            if (pready !== 1'b1)
                hung <= 1'b1;
            psel    <= 1'b0;
            penable <= 1'b0;
            // released bus shows no stale address or data
            paddr   <= ~a;
            pwdata  <= ~d;
            @(posedge pclk);
        end
    endtask : xfer

    // enables first, then the ordered key pair as one uninterrupted burst
    task automatic arm(input logic [1:0] en);
        logic [31:0] rd;
        logic        e;
        begin
            xfer(1'b1, OFS_CTRL, {30'h0, en}, rd, e);
            xfer(1'b1, OFS_KEY, {24'h0, KEY_FIRST}, rd, e);
            xfer(1'b1, OFS_KEY, {24'h0, KEY_SECOND}, rd, e);
        end
    endtask : arm
endmodule : fpec_core_model

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import fpec_pkg::*;
    localparam int ER_CYC = 1200;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic          dbg_ack, core_stall, sys_rst_req, hung;
    logic [15:0]   paddr;
    logic [31:0]   pwdata, prdata, rdv;
    fpec_dbg_req_t dbg_req;
    fpec_xram_t    xram;
    int            bad_count, n_tests, stall_run, stall_last, op_cnt, xr_cnt, rst_cnt, k;
    bit            dbg_hung;
    logic [15:0]   bad_key [4] = '{16'h1200, 16'hA512, 16'hF100, 16'hA5A5};

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    fpec_top #(.ERASE_CYCLES(ER_CYC)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dbg_req(dbg_req), .dbg_ack(dbg_ack),
        .xram(xram), .core_stall(core_stall), .sys_rst_req(sys_rst_req));

    fpec_core_model core (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hung(hung));

    // stall run lengths, data memory writes and reset requests seen at the ports
    always @(posedge pclk)
    begin
        if (core_stall === 1'b1)
            stall_run <= stall_run + 1;
        else if (stall_run != 0)
        begin
            stall_last <= stall_run;
            op_cnt     <= op_cnt + 1;
            stall_run  <= 0;
        end
        if (xram.we === 1'b1)
            xr_cnt <= xr_cnt + 1;
        if (sys_rst_req === 1'b1)
            rst_cnt <= rst_cnt + 1;
        if (hung === 1'b1 || dbg_hung)
        begin
            bad_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [15:0] a);
        core.xfer(1'b0, a, 32'h0, rdv, err);
    endtask : rd

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] unused;
        core.xfer(1'b1, a, d, unused, err);
    endtask : wr

    task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
        rd(a);
        chk(rdv, exp);
    endtask : rchk

    function automatic logic [15:0] win(input logic [12:0] a);
        return 16'h8000 | {1'b0, a, 2'b00};
    endfunction : win

    task automatic do_reset(input int n);
        presetn <= 1'b0;
        repeat (n) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : do_reset

    // debug request held until acknowledged, dropped at the edge that sees the ack
    task automatic dbg_op(input logic er, input logic [12:0] a, input logic [7:0] d);
        int n;
        begin
            dbg_req <= '{valid: 1'b1, erase: er, addr: a, data: d};
            n = 0;
            do
            begin
                @(posedge pclk);
                n++;
            end
            while (dbg_ack !== 1'b1 && n < 100);
            chk({31'h0, dbg_ack}, 32'h1);
            dbg_hung = (dbg_ack !== 1'b1);
            dbg_req <= '{valid: 1'b0, erase: 1'b0, addr: ~a, data: ~d};
        end
    endtask : dbg_op

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    initial
    begin
        presetn = 1'b0;
        dbg_req = '0;
        {bad_count, n_tests, stall_run, stall_last, op_cnt, xr_cnt, rst_cnt} = '0;
        do_reset(20);
        // reset state and an unmapped address
        rchk(OFS_CTRL, 32'h0);
        rchk(OFS_KEY, 32'h0);
        rchk(OFS_STAT, 32'h0);
        rchk(16'h0010, 32'h0);
        chk({31'h0, err}, 32'h1);
        // blank device ignores a software program
        core.arm(2'h1);
        wr(win(13'h0010), 32'h00);
        rchk(OFS_KEY, 32'h2);
        chk(op_cnt, 0);
        do_reset(2);
        // debug port erase and byte program
        dbg_op(1'b1, 13'h0000, 8'h00);
        rchk(OFS_STAT, 32'h4);
        chk(stall_last, ER_CYC);
        rchk(win(13'h01FF), 32'hFF);
        dbg_op(1'b0, 13'h0020, 8'h3C);
        rchk(win(13'h0020), 32'h3C);
        chk(stall_last, WRITE_CYC);
        // software byte program with a long gap between the keys
        wr(OFS_CTRL, 32'h1);
        wr(OFS_KEY, 32'hA5);
        rchk(OFS_KEY, 32'h1);
        repeat (300) @(posedge pclk);
        wr(OFS_KEY, 32'hF1);
        rchk(OFS_KEY, 32'h2);
        k = xr_cnt;
        wr(win(13'h0010), 32'h5A);
        rchk(OFS_KEY, 32'h0);
        chk(stall_last, WRITE_CYC);
        rchk(win(13'h0010), 32'h5A);
        rchk(OFS_CTRL, 32'h1);
        chk(xr_cnt, k);
        // programming only clears bits
        core.arm(2'h1);
        wr(win(13'h0010), 32'hF0);
        rchk(win(13'h0010), 32'h50);
        // page erase through any address, data byte ignored
        core.arm(2'h3);
        wr(win(13'h01F3), 32'h00);
        rchk(win(13'h0010), 32'hFF);
        rchk(win(13'h0020), 32'hFF);
        chk(stall_last, ER_CYC);
        // unrouted move goes to data memory and leaves the keys alone
        core.arm(2'h0);
        k = xr_cnt;
        wr(win(13'h0030), 32'h11);
        rchk(OFS_KEY, 32'h2);
        chk(xr_cnt, k + 1);
        chk({11'h0, xram.addr, xram.data}, {11'h0, 13'h0030, 8'h11});
        // write above the user limit
        wr(OFS_CTRL, 32'h1);
        wr(win(13'h1E00), 32'h00);
        rchk(OFS_STAT, 32'h6);
        chk(rst_cnt, 1);
        rchk(OFS_KEY, 32'h0);
        rchk(OFS_CTRL, 32'h0);
        wr(OFS_STAT, 32'h2);
        rchk(OFS_STAT, 32'h4);
        // operation before unlocking blocks until reset
        k = op_cnt;
        wr(OFS_CTRL, 32'h1);
        wr(win(13'h0040), 32'h00);
        rchk(OFS_KEY, 32'h3);
        core.arm(2'h1);
        wr(win(13'h0040), 32'h00);
        rchk(OFS_KEY, 32'h3);
        chk(op_cnt, k);
        // wrong or misordered keys, each from a fresh reset
        foreach (bad_key[i])
        begin
            do_reset(2);
            wr(OFS_KEY, {24'h0, bad_key[i][15:8]});
            if (bad_key[i][7:0] != 8'h00)
                wr(OFS_KEY, {24'h0, bad_key[i][7:0]});
            rchk(OFS_KEY, 32'h3);
        end
        do_reset(2);
        rchk(OFS_KEY, 32'h0);
        stop_test();
    end
endmodule : testbench
